// *** core/pap_core.sv ***
`timescale 1ns/1ps
// Function
// - Seal protective action until feedback confirms position
// - Protective state equals de-energized output
// - Breaker undervoltage coil and shunt relay together
// - Shunt relay de-energized opens breaker
// - One nonsafety enable gates all components
// - Fourteen individual hardwired nonsafety inputs
// - Nonsafety input mapping set by straps
// - Operate position forwards algorithm trip unchanged
// - Out of service uses trip/bypass switch
// - Out of service bypass forces no trip
// - Out of service trip forces trip
// - Lost or removed module uses trip/bypass
// - Loss of ventilation AC waits ten minutes
// - Manual switches actuate habitability and isolation
// - Habitability command starts system, closes envelope
// - Isolation command closes outside air dampers
// - Valve solenoid energized closed, released opens
// - Damper output closed normal, open actuates
// - Transient filter delays loss start and reset
module pap_core import pap_pkg::*; #(
   parameter logic [DLY_W-1:0] LOSS_DLY = LOSS_DLY_CYC,
   parameter logic [DLY_W-1:0] TD_DLY   = TD_CYC
) (
   // Clock and reset
   input  wire logic                clk,
   input  wire logic                resetn,
   // Switch, feedback and nonsafety pins
   input  wire pap_pins_s           pins,
   // Field drive
   output pap_field_s               field,
   // Status
   output logic [NUM_SF-1:0]        sf_fwd,
   output logic [NUM_COMP-1:0]      seal_in,
   output logic [NUM_COMP-1:0]      actuated,
   output logic                     ac_loss_qual
);

   pap_pins_s            ps;
   logic                 ac_filt;
   logic                 sfm_ok;
   logic [NUM_SF-1:0]    sf_sel;
   logic [NUM_COMP-1:0]  demand;
   logic [NUM_COMP-1:0]  active;
   logic [NUM_COMP-1:0]  ns_act;
   logic [NUM_COMP-1:0]  ns_norm;
   logic [2**SEL_W-1:0]  ns_all;
   logic [NUM_COMP-1:0]  next_seal;
   logic [NUM_COMP-1:0]  next_act;
   pap_field_s           next_field;

   // Every pin through four flops
   pap_sync #(
      .W ($bits(pap_pins_s))
   ) u_sync (
      .clk    (clk),
      .resetn (resetn),
      .d      (pins),
      .q      (ps)
   );

   // Transient filter on both edges
   pap_delay #(
      .DLY  (TD_DLY),
      .BOTH (1'b1)
   ) u_td (
      .clk    (clk),
      .resetn (resetn),
      .din    (ps.ac_lost),
      .dout   (ac_filt)
   );

   // Long qualification, cleared at once
   pap_delay #(
      .DLY  (LOSS_DLY),
      .BOTH (1'b0)
   ) u_loss (
      .clk    (clk),
      .resetn (resetn),
      .din    (ac_filt),
      .dout   (ac_loss_qual)
   );

   // Safety function source select
   always_comb begin
      sfm_ok = ps.safety_function_module.comm_ok & ps.safety_function_module.present;
      if (!sfm_ok) begin
         sf_sel = {NUM_SF{ps.safety_function_module.trip_byp}};
      end else if (ps.safety_function_module.out_of_service_switch) begin
         sf_sel = {NUM_SF{ps.safety_function_module.trip_byp}};
      end else begin
         sf_sel = ps.alg_trip;
      end
   end

   // Protective demand per component
   always_comb begin
      demand          = '0;
      demand[CMP_RTB] = sf_sel[CMP_RTB];
      demand[CMP_VLV] = sf_sel[CMP_VLV];
      demand[CMP_CRE] = sf_sel[CMP_CRE] | ps.man_hab | ac_loss_qual;
      demand[CMP_OAI] = sf_sel[CMP_OAI] | ps.man_oa;
   end

   // Nonsafety inputs padded to the full strap range
   assign ns_all = {{(2**SEL_W-NUM_NS){1'b0}}, ps.ns_in};

   // Seal-in, nonsafety gating and component state
   for (genvar c = 0; c < NUM_COMP; c++) begin : g_comp
      logic [SEL_W-1:0] sa;
      logic [SEL_W-1:0] sn;
      assign sa = ps.ns_sel_act[c];
      assign sn = ps.ns_sel_norm[c];

      always_comb begin
         ns_act[c]  = ps.ns_en & (32'(sa) < NUM_NS) & ns_all[sa];
         ns_norm[c] = ps.ns_en & (32'(sn) < NUM_NS) & ns_all[sn];
         next_seal[c] = demand[c] | (seal_in[c] & ~ps.fb_at_demand[c]);
         active[c]    = demand[c] | seal_in[c];
         if (active[c]) begin
            next_act[c] = 1'b1;
         end else if (ns_norm[c]) begin
            next_act[c] = 1'b0;
         end else if (ns_act[c]) begin
            next_act[c] = 1'b1;
         end else begin
            next_act[c] = actuated[c];
         end
      end
   end

   // Field drive, de-energized when actuated
   always_comb begin
      next_field             = FIELD_RST;
      next_field.uv_coil     = ~next_act[CMP_RTB];
      next_field.shunt_relay = ~next_act[CMP_RTB];
      next_field.valve_sol   = ~next_act[CMP_VLV];
      next_field.cre_damper  = ~next_act[CMP_CRE];
      next_field.hab_standby = ~next_act[CMP_CRE];
      next_field.oa_damper   = ~next_act[CMP_OAI];
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         seal_in  <= '0;
         actuated <= ACT_RST;
         field    <= FIELD_RST;
         sf_fwd   <= '0;
      end else begin
         seal_in  <= next_seal;
         actuated <= next_act;
         field    <= next_field;
         sf_fwd   <= sf_sel;
      end
   end

   // Checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (!resetn);

   AST_SEAL_HOLD: assert property (
      (seal_in & ~ps.fb_at_demand) != '0 |=>
         ((seal_in & $past(seal_in & ~ps.fb_at_demand)) == $past(seal_in & ~ps.fb_at_demand)))
      else $error("seal dropped before position feedback");

   AST_FAILSAFE: assert property (
      (active != '0) |=> ((actuated & $past(active)) == $past(active)))
      else $error("protective demand did not reach actuated state");

   AST_RTB_PAIR: assert property (
      field.uv_coil == field.shunt_relay && field.uv_coil == !actuated[CMP_RTB])
      else $error("breaker coil and relay disagree");

   AST_SHUNT: assert property (
      demand[CMP_RTB] |=> !field.shunt_relay ##1 !field.shunt_relay || !seal_in[CMP_RTB])
      else $error("shunt relay energized during breaker trip");

   AST_NS_GATE: assert property (
      !ps.ns_en |=> ((~actuated & $past(actuated)) == '0))
      else $error("component restored without nonsafety enable");

   AST_OP_FWD: assert property (
      sfm_ok && !ps.safety_function_module.out_of_service_switch |=> sf_fwd == $past(ps.alg_trip))
      else $error("operate position did not forward algorithm result");

   AST_BYPASS: assert property (
      sfm_ok && ps.safety_function_module.out_of_service_switch && !ps.safety_function_module.trip_byp |-> sf_sel == '0)
      else $error("bypass did not force no trip");

   AST_FORCE_TRIP: assert property (
      sfm_ok && ps.safety_function_module.out_of_service_switch && ps.safety_function_module.trip_byp |=> sf_fwd == '1)
      else $error("trip position did not force trip");

   AST_COMM_LOSS: assert property (
      !sfm_ok |-> sf_sel == {NUM_SF{ps.safety_function_module.trip_byp}})
      else $error("lost module not taken from trip/bypass");

   AST_MANUAL: assert property (
      ps.man_hab |=> !field.hab_standby && !field.cre_damper)
      else $error("manual habitability actuate ignored");

   AST_OA_ISO: assert property (
      sf_sel[CMP_OAI] |=> !field.oa_damper)
      else $error("outside air dampers not closed");

   AST_HAB_AUTO: assert property (
      sf_sel[CMP_CRE] |=> !field.hab_standby && !field.cre_damper)
      else $error("habitability command did not close envelope");

   AST_LOSS_HAB: assert property (
      ac_loss_qual |=> !field.hab_standby && !field.cre_damper)
      else $error("qualified loss of ventilation AC ignored");

   AST_DAMPER_NORM: assert property (
      field.oa_damper == !actuated[CMP_OAI] && field.cre_damper == !actuated[CMP_CRE])
      else $error("damper output disagrees with component state");

   AST_VALVE: assert property (
      demand[CMP_VLV] |=> !field.valve_sol [*2] or ##1 ps.fb_at_demand[CMP_VLV])
      else $error("valve solenoid not released on actuation");

   AST_PRIORITY: assert property (
      (active & ns_norm) != '0 |=> ((actuated & $past(active & ns_norm)) == $past(active & ns_norm)))
      else $error("nonsafety request overrode protective command");

   COV_SEAL_RELEASE: cover property (seal_in[CMP_RTB] ##1 !seal_in[CMP_RTB]);
   COV_OOS_BYPASS: cover property (sfm_ok && ps.safety_function_module.out_of_service_switch && !ps.safety_function_module.trip_byp);
   COV_NS_RESTORE: cover property (actuated[CMP_VLV] ##1 !actuated[CMP_VLV]);
   COV_AC_LOSS: cover property ($rose(ac_loss_qual));

endmodule

// *** shared/pap_pkg.sv ***
package pap_pkg;

   // Sizes
   localparam int NUM_SF   = 4;
   localparam int NUM_COMP = 4;
   localparam int NUM_NS   = 14;
   localparam int SEL_W    = 4;
   localparam int DLY_W    = 36;

   // Component and safety function indices
   localparam int CMP_RTB = 0;
   localparam int CMP_VLV = 1;
   localparam int CMP_CRE = 2;
   localparam int CMP_OAI = 3;

   // Timing
   localparam logic [31:0] CLK_HZ      = 32'h0131_2D00;
   localparam logic [31:0] LOSS_DLY_MIN = 32'h0000_000A;
   localparam logic [31:0] TD_MS       = 32'h0000_01F4;
   localparam logic [DLY_W-1:0] LOSS_DLY_CYC =
      DLY_W'(64'(LOSS_DLY_MIN) * 64'h3C * 64'(CLK_HZ));
   localparam logic [DLY_W-1:0] TD_CYC =
      DLY_W'((64'(TD_MS) * 64'(CLK_HZ)) / 64'h3E8);

   // Safety function module switches and health
   typedef struct packed {
      logic out_of_service_switch;
      logic trip_byp;
      logic comm_ok;
      logic present;
   } pap_sfm_s;

   // All pins entering the block
   typedef struct packed {
      logic [NUM_SF-1:0]                    alg_trip;
      pap_sfm_s                             safety_function_module;
      logic                                 ns_en;
      logic [NUM_NS-1:0]                    ns_in;
      logic [NUM_COMP-1:0][SEL_W-1:0]       ns_sel_act;
      logic [NUM_COMP-1:0][SEL_W-1:0]       ns_sel_norm;
      logic                                 man_hab;
      logic                                 man_oa;
      logic [NUM_COMP-1:0]                  fb_at_demand;
      logic                                 ac_lost;
   } pap_pins_s;

   // Field drive, high means energized
   typedef struct packed {
      logic uv_coil;
      logic shunt_relay;
      logic valve_sol;
      logic cre_damper;
      logic hab_standby;
      logic oa_damper;
   } pap_field_s;

   localparam pap_field_s FIELD_RST = '0;
   localparam logic [NUM_COMP-1:0] ACT_RST = 4'hF;

endpackage

// *** core/pap_sync.sv ***
`timescale 1ns/1ps
module pap_sync import pap_pkg::*; #(
   parameter int W = 1
) (
   // Clock and reset
   input  wire logic         clk,
   input  wire logic         resetn,
   // Data
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);

   logic [W-1:0] s1;
   logic [W-1:0] s2;
   logic [W-1:0] s3;
   logic [W-1:0] next_q;

   // Take a bit once stages two and three agree
   always_comb begin
      next_q = (s2 & s3) | (q & (s2 | s3));
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         s1 <= '0;
         s2 <= '0;
         s3 <= '0;
         q  <= '0;
      end else begin
         s1 <= d;
         s2 <= s1;
         s3 <= s2;
         q  <= next_q;
      end
   end

endmodule

// *** core/pap_delay.sv ***
`timescale 1ns/1ps
module pap_delay import pap_pkg::*; #(
   parameter logic [DLY_W-1:0] DLY  = TD_CYC,
   parameter bit               BOTH = 1'b1
) (
   // Clock and reset
   input  wire logic clk,
   input  wire logic resetn,
   // Level in and qualified level out
   input  wire logic din,
   output logic      dout
);

   logic [DLY_W-1:0] cnt;
   logic [DLY_W-1:0] next_cnt;
   logic             next_dout;

   // Level must stand DLY cycles; without BOTH a fall passes at once
   always_comb begin
      next_cnt  = '0;
      next_dout = dout;
      if (din == dout) begin
         next_cnt = '0;
      end else if (!BOTH && !din) begin
         next_dout = 1'b0;
      end else if (cnt >= DLY - 1'b1) begin
         next_dout = din;
      end else begin
         next_cnt = cnt + 1'b1;
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         cnt  <= '0;
         dout <= 1'b0;
      end else begin
         cnt  <= next_cnt;
         dout <= next_dout;
      end
   end

   AST_DLY_QUAL: assert property (@(posedge clk) disable iff (!resetn)
      ($changed(dout) && (BOTH || dout)) |-> ($past(cnt) >= DLY - 1'b1))
      else $error("delayed level changed before its count");

endmodule

// *** tb/pap_field_model.sv ***
`timescale 1ns/1ps
module pap_field_model import pap_pkg::*; (
   // Clock and reset
   input  wire logic                clk,
   input  wire logic                resetn,
   // Drive from the block, feedback delay
   input  wire pap_field_s          field,
   input  wire logic [7:0]          dly,
   // Position feedback
   output logic [NUM_COMP-1:0]      fb
);
   logic [NUM_COMP-1:0]             deen;
   logic [NUM_COMP-1:0][7:0]        cnt;
   logic [NUM_COMP-1:0][7:0]        next_cnt;

   // Loads move to the protective position only when released
   assign deen = {~field.oa_damper, ~field.cre_damper, ~field.valve_sol,
                  ~field.uv_coil & ~field.shunt_relay};

   always_comb begin
      for (int c = 0; c < NUM_COMP; c++) begin
         next_cnt[c] = !deen[c] ? 8'h00 : (cnt[c] == dly) ? cnt[c] : cnt[c] + 8'h01;
         fb[c]       = deen[c] && (cnt[c] == dly);
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         cnt <= '0;
      end else begin
         cnt <= next_cnt;
      end
   end
endmodule

// *** tb/protective_actuation_priority_test.sv ***
`timescale 1ns/1ps
module protective_actuation_priority_test import pap_pkg::*;;
   logic                clk = 1'b0;
   logic                resetn = 1'b0;
   pap_pins_s           p;
   pap_pins_s           pins;
   pap_field_s          field;
   logic [NUM_SF-1:0]   sf_fwd;
   logic [NUM_COMP-1:0] seal_in;
   logic [NUM_COMP-1:0] actuated;
   logic [NUM_COMP-1:0] fb;
   logic                ac_loss_qual;
   logic [7:0]          dly = 8'h14;
   int                  fails = 0;
   int                  n_tests = 0;

   always #25 clk = ~clk;

   always_comb begin
      pins = p;
      pins.fb_at_demand = fb;
   end

   pap_core #(.LOSS_DLY(36'h5), .TD_DLY(36'h3)) u_pap_core (.clk(clk), .resetn(resetn), .pins(pins),
      .field(field), .sf_fwd(sf_fwd), .seal_in(seal_in), .actuated(actuated), .ac_loss_qual(ac_loss_qual));
   pap_field_model u_pap_field_model (.clk(clk), .resetn(resetn), .field(field), .dly(dly), .fb(fb));

   task automatic step(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         fails++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic results;
      $display("checks=%0d fails=%0d", n_tests, fails);
      if (fails == 0 && n_tests > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   // Bounded wait for seals and loss qualification to clear
   task automatic settle;
      int k;
      k = 0;
      while ((seal_in !== 4'h0 || ac_loss_qual !== 1'b0) && k < 200) begin
         step(1);
         k++;
      end
      chk(k < 200, 1'b1);
      if (k == 200) begin
         results();
      end
   endtask

   // Expected field drive for a component state, energized when normal
   function automatic logic [5:0] drive(input logic [3:0] a);
      return {~a[CMP_RTB], ~a[CMP_RTB], ~a[CMP_VLV], ~a[CMP_CRE], ~a[CMP_CRE], ~a[CMP_OAI]};
   endfunction

   task automatic restore(input logic en, input logic [3:0] was, input string s);
      p.ns_en = en;
      p.ns_in = 14'h000F;
      step(7);
      chk(actuated, en ? 4'h0 : was);
      chk(field, drive(en ? 4'h0 : was));
      p.ns_in = 14'h0000;
      step(7);
      chk(actuated, en ? 4'h0 : was);
      $display("test %s done", s);
   endtask

   // Unmapped strap and normal-over-actuate order
   task automatic straps;
      p.ns_sel_act[CMP_VLV] = 4'hE;
      p.ns_en = 1'b1;
      p.ns_in = 14'h00F0;
      step(7);
      chk(actuated, 4'hD);
      p.ns_in = 14'h00FF;
      step(7);
      chk(actuated, 4'h0);
      chk(field, 6'h3F);
      p.ns_in = 14'h0000;
      p.ns_sel_act[CMP_VLV] = 4'h5;
      step(7);
      $display("test straps done");
   endtask

   task automatic ns_act;
      p.ns_en = 1'b1;
      p.ns_in = 14'h00F0;
      step(7);
      chk(actuated, 4'hF);
      chk(field, 6'h00);
      chk(seal_in, 4'h0);
      p.ns_in = 14'h0000;
      restore(1'b1, 4'h0, "ns_act");
   endtask

   task automatic trip(input int c);
      logic [5:0] m;
      m = (c == 0) ? 6'h30 : (c == 1) ? 6'h08 : (c == 2) ? 6'h06 : 6'h01;
      p.alg_trip = 4'h1 << c;
      step(6);
      chk(sf_fwd, 4'h1 << c);
      chk(seal_in, 4'h1 << c);
      chk(field, 6'h3F & ~m);
      p.alg_trip = 4'h0;
      p.ns_in = 14'h0001 << c;
      step(8);
      chk(actuated, 4'h1 << c);
      chk(seal_in, 4'h1 << c);
      p.ns_in = 14'h0000;
      settle();
      restore(1'b0, 4'h1 << c, "trip_refused");
      restore(1'b1, 4'h0, "trip");
   endtask

   task automatic out_of_service_switch;
      p.alg_trip = 4'hF;
      p.safety_function_module.out_of_service_switch = 1'b1;
      step(6);
      chk(sf_fwd, 4'h0);
      p.alg_trip = 4'h0;
      p.safety_function_module.trip_byp = 1'b1;
      step(6);
      chk(sf_fwd, 4'hF);
      p.safety_function_module.out_of_service_switch = 1'b0;
      p.safety_function_module.comm_ok = 1'b0;
      step(6);
      chk(sf_fwd, 4'hF);
      p.safety_function_module.comm_ok = 1'b1;
      p.safety_function_module.present = 1'b0;
      step(6);
      chk(sf_fwd, 4'hF);
      p.safety_function_module.present = 1'b1;
      p.safety_function_module.trip_byp = 1'b0;
      settle();
      restore(1'b1, 4'h0, "oos");
   endtask

   task automatic manual;
      p.man_hab = 1'b1;
      step(6);
      chk(actuated, 4'h4);
      p.man_hab = 1'b0;
      p.man_oa = 1'b1;
      step(6);
      chk(actuated, 4'hC);
      chk(field, 6'h38);
      p.man_oa = 1'b0;
      settle();
      restore(1'b1, 4'h0, "manual");
   endtask

   task automatic ac_loss;
      int k;
      p.ac_lost = 1'b1;
      step(2);
      p.ac_lost = 1'b0;
      step(20);
      chk(ac_loss_qual, 1'b0);
      p.ac_lost = 1'b1;
      k = 0;
      while (ac_loss_qual !== 1'b1 && k < 200) begin
         step(1);
         k++;
      end
      chk(k >= 11 && k < 200, 1'b1);
      if (k == 200) begin
         results();
      end
      step(2);
      chk(actuated, 4'h4);
      p.ac_lost = 1'b0;
      settle();
      restore(1'b1, 4'h0, "ac_loss");
   endtask

   initial begin
      p = '0;
      p.safety_function_module.comm_ok = 1'b1;
      p.safety_function_module.present = 1'b1;
      p.ns_sel_norm = {4'h3, 4'h2, 4'h1, 4'h0};
      p.ns_sel_act = {4'h7, 4'h6, 4'h5, 4'h4};
      step(4);
      chk(field, FIELD_RST);
      chk(actuated, ACT_RST);
      resetn = 1'b1;
      restore(1'b0, 4'hF, "reset_refused");
      restore(1'b1, 4'h0, "reset");
      ns_act();
      straps();
      for (int c = 0; c < NUM_COMP; c++) begin
         trip(c);
      end
      out_of_service_switch();
      manual();
      ac_loss();
      results();
   end
endmodule
